// File: fpmc_addr_map.sv
package fpmc_pkg;
	localparam int             WORD_W      = 32;
	localparam int             ADDR_W      = 12;
	localparam int             IDX_W       = 12;
	localparam logic [IDX_W-1:0] CFG_WORDS = 12'h400;
	localparam logic [IDX_W-1:0] USER_WORDS = 12'h200;
	localparam logic [IDX_W-1:0] ALL_WORDS = 12'h600;
	localparam logic [2:0]     FR_WORDS    = 3'h4;
	localparam logic [1:0]     SEC_CFG     = 2'h0;
	localparam logic [1:0]     SEC_USER    = 2'h1;
	localparam logic [1:0]     SEC_FEAT    = 2'h2;
	localparam logic [1:0]     SEC_END     = 2'h3;
	localparam int             MB_CFG      = 0;
	localparam int             MB_USER     = 1;
	localparam int             MB_FEAT     = 2;
	localparam logic [2:0]     MASK_OFF    = 3'h7;
	localparam logic [2:0]     MASK_BG     = 3'h3;
	localparam logic [1:0]     ROLE_IMAGE  = 2'h0;
	localparam logic [1:0]     ROLE_BRAM   = 2'h1;
	localparam logic [1:0]     ROLE_GEN    = 2'h2;
	localparam int             CLK_NS      = 8;
	localparam int             INIT_NS     = 1000;
	localparam logic [7:0]     INIT_CYC    = 8'((INIT_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [1:0] {FOP_READ, FOP_ERASE, FOP_PROG} fpmc_fop_t;
	typedef enum logic [1:0] {CMD_OFFLINE, CMD_BACKGROUND, CMD_RELOAD, CMD_NONE} fpmc_cmd_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
module fpmc_addr_map
	import fpmc_pkg::*;
(
	input  wire logic [IDX_W-1:0]  idx,
	input  wire logic [1:0]        sector_role,
	output logic      [1:0]        sector,
	output logic      [ADDR_W-1:0] addr,
	output logic                   in_range
);
	// the image runs through the config sector and on into user flash as one linear space
	always_comb begin
		sector   = SEC_CFG;
		addr     = idx;
		in_range = 1'b1;
		if (idx >= CFG_WORDS) begin
			sector   = SEC_USER;
			addr     = idx - CFG_WORDS;
			// user flash holds image words only in its image role
			in_range = (sector_role == ROLE_IMAGE) && (idx < ALL_WORDS);
		end
	end
endmodule
`default_nettype wire

// File: fpmc_top.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_top
	import fpmc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              cmd_valid,
	input  wire fpmc_cmd_t         cmd_op,
	input  wire logic [2:0]        cmd_mask,
	input  wire logic [1:0]        sector_role,
	input  wire logic              wr_valid,
	input  wire logic [WORD_W-1:0] wr_data,
	input  wire logic              wr_last,
	output logic                   wr_ready,
	output logic                   flash_req,
	output fpmc_fop_t              flash_op,
	output logic [1:0]             flash_sec,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [WORD_W-1:0]      flash_wdata,
	input  wire logic              flash_ack,
	input  wire logic [WORD_W-1:0] flash_rdata,
	output logic                   sram_wr_valid,
	output logic [WORD_W-1:0]      sram_wdata,
	output logic                   busy,
	output logic                   user_halt,
	output logic                   init_status_n,
	output logic                   done,
	output logic                   rpll_rst_req,
	output logic                   range_err,
	output logic                   image_pending
);
	typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_FEAT, ST_IMG, ST_INIT, ST_LOAD, ST_NOIMG} fpmc_st_t;

	typedef struct packed {
		fpmc_st_t          st;
		logic              is_bg;
		logic [2:0]        mask;
		logic [1:0]        cur_sec;
		logic [2:0]        fr_cnt;
		logic [IDX_W-1:0]  word_idx;
		logic [IDX_W-1:0]  img_len;
		logic              last_pend;
		logic [7:0]        init_cnt;
		logic              wr_ready;
		logic              flash_req;
		fpmc_fop_t         flash_op;
		logic [1:0]        flash_sec;
		logic [ADDR_W-1:0] flash_addr;
		logic [WORD_W-1:0] flash_wdata;
		logic              sram_wr_valid;
		logic [WORD_W-1:0] sram_wdata;
		logic              busy;
		logic              user_halt;
		logic              init_n;
		logic              done;
		logic              rpll_rst;
		logic              err;
		logic              pending;
	} fpmc_state_t;

	fpmc_state_t       s_r;
	fpmc_state_t       s_nxt;
	logic [1:0]        map_sec;
	logic [ADDR_W-1:0] map_addr;
	logic              map_ok;
	logic              take;

	fpmc_addr_map u_map (
		.idx         (s_r.word_idx),
		.sector_role (sector_role),
		.sector      (map_sec),
		.addr        (map_addr),
		.in_range    (map_ok)
	);

	assign take = wr_valid && s_r.wr_ready;

	always_comb begin
		s_nxt               = s_r;
		s_nxt.sram_wr_valid = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				if (cmd_valid && (cmd_op == CMD_OFFLINE || cmd_op == CMD_BACKGROUND)) begin
					s_nxt.is_bg     = (cmd_op == CMD_BACKGROUND);
					if (cmd_op == CMD_OFFLINE) begin
						s_nxt.mask      = (cmd_mask == 3'h0) ? MASK_OFF : cmd_mask;
						s_nxt.user_halt = 1'b1;
					end else begin
						// feature row is masked off even if asked
						s_nxt.mask = (cmd_mask == 3'h0) ? MASK_BG : (cmd_mask & MASK_BG);
					end
					s_nxt.cur_sec   = SEC_CFG;
					s_nxt.fr_cnt    = 3'h0;
					s_nxt.word_idx  = '0;
					s_nxt.last_pend = 1'b0;
					s_nxt.err       = 1'b0;
					s_nxt.busy      = 1'b1;
					s_nxt.st        = ST_ERASE;
				end else if (cmd_valid && cmd_op == CMD_RELOAD) begin
					// clears the running image first, so user logic halts too
					s_nxt.init_n    = 1'b0;
					s_nxt.done      = 1'b0;
					s_nxt.user_halt = 1'b1;
					s_nxt.pending   = 1'b0;
					s_nxt.init_cnt  = INIT_CYC;
					s_nxt.st        = ST_INIT;
				end
			end
			ST_ERASE: begin
				// one erase per selected sector, walked in sector order
				if (s_r.flash_req) begin
					if (flash_ack) begin
						s_nxt.flash_req = 1'b0;
						s_nxt.rpll_rst  = 1'b0;
						s_nxt.cur_sec   = s_r.cur_sec + 2'h1;
					end
				end else if (s_r.cur_sec == SEC_END) begin
					s_nxt.wr_ready = 1'b1;
					s_nxt.st       = s_r.mask[MB_FEAT] ? ST_FEAT : ST_IMG;
				end else if (s_r.mask[s_r.cur_sec]) begin
					s_nxt.flash_req  = 1'b1;
					s_nxt.flash_op   = FOP_ERASE;
					s_nxt.flash_sec  = s_r.cur_sec;
					s_nxt.flash_addr = '0;
					s_nxt.rpll_rst   = s_r.is_bg;
				end else begin
					s_nxt.cur_sec = s_r.cur_sec + 2'h1;
				end
			end
			ST_FEAT: begin
				// feature row words come first and go to their own sector
				if (take) begin
					s_nxt.wr_ready    = 1'b0;
					s_nxt.flash_req   = 1'b1;
					s_nxt.flash_op    = FOP_PROG;
					s_nxt.flash_sec   = SEC_FEAT;
					s_nxt.flash_addr  = {{(ADDR_W-3){1'b0}}, s_r.fr_cnt};
					s_nxt.flash_wdata = wr_data;
				end
				if (s_r.flash_req && flash_ack) begin
					s_nxt.flash_req = 1'b0;
					s_nxt.wr_ready  = 1'b1;
					s_nxt.fr_cnt    = s_r.fr_cnt + 3'h1;
					if (s_r.fr_cnt == FR_WORDS - 3'h1) begin
						s_nxt.st = ST_IMG;
					end
				end
			end
			ST_IMG: begin
				if (take) begin
					s_nxt.word_idx  = s_r.word_idx + 12'h001;
					s_nxt.last_pend = wr_last;
					if (map_ok && s_r.mask[map_sec]) begin
						s_nxt.wr_ready    = 1'b0;
						s_nxt.flash_req   = 1'b1;
						s_nxt.flash_op    = FOP_PROG;
						s_nxt.flash_sec   = map_sec;
						s_nxt.flash_addr  = map_addr;
						s_nxt.flash_wdata = wr_data;
					end else begin
						// word is dropped; image must come from external flash
						s_nxt.err = 1'b1;
					end
					s_nxt.wr_ready = s_nxt.wr_ready && !wr_last; // nothing is taken past the last word
				end
				if (s_r.flash_req && flash_ack) begin
					s_nxt.flash_req = 1'b0;
					s_nxt.wr_ready  = 1'b1;
				end
				if (s_r.last_pend && (!s_r.flash_req || flash_ack)) begin
					s_nxt.wr_ready  = 1'b0;
					s_nxt.last_pend = 1'b0;
					s_nxt.img_len   = s_r.word_idx;
					s_nxt.busy      = 1'b0;
					s_nxt.user_halt = s_r.is_bg && s_r.user_halt;
					s_nxt.pending   = s_r.is_bg;
					s_nxt.st        = ST_IDLE;
				end
			end
			ST_INIT: begin
				if (s_r.init_cnt == 8'h01) begin
					s_nxt.init_n   = 1'b1;
					s_nxt.word_idx = '0;
					s_nxt.st       = (s_r.img_len == '0) ? ST_NOIMG : ST_LOAD;
				end else begin
					s_nxt.init_cnt = s_r.init_cnt - 8'h01;
				end
			end
			ST_LOAD: begin
				if (s_r.flash_req) begin
					if (flash_ack) begin
						s_nxt.flash_req     = 1'b0;
						s_nxt.sram_wr_valid = 1'b1;
						s_nxt.sram_wdata    = flash_rdata;
						s_nxt.word_idx      = s_r.word_idx + 12'h001;
					end
				end else if (s_r.word_idx == s_r.img_len) begin
					s_nxt.done      = 1'b1;
					s_nxt.user_halt = 1'b0;
					s_nxt.st        = ST_IDLE;
				end else begin
					s_nxt.flash_req  = 1'b1;
					s_nxt.flash_op   = FOP_READ;
					s_nxt.flash_sec  = map_sec;
					s_nxt.flash_addr = map_addr;
				end
			end
			// no valid image: configuration never completes, only reset leaves
			ST_NOIMG: begin
				s_nxt.st = ST_NOIMG;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r           <= '0;
			s_r.st        <= ST_IDLE;
			s_r.flash_op  <= FOP_READ;
			s_r.user_halt <= 1'b1;
			s_r.init_n    <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wr_ready      = s_r.wr_ready;
	assign flash_req     = s_r.flash_req;
	assign flash_op      = s_r.flash_op;
	assign flash_sec     = s_r.flash_sec;
	assign flash_addr    = s_r.flash_addr;
	assign flash_wdata   = s_r.flash_wdata;
	assign sram_wr_valid = s_r.sram_wr_valid;
	assign sram_wdata    = s_r.sram_wdata;
	assign busy          = s_r.busy;
	assign user_halt     = s_r.user_halt;
	assign init_status_n = s_r.init_n;
	assign done          = s_r.done;
	assign rpll_rst_req  = s_r.rpll_rst;
	assign range_err     = s_r.err;
	assign image_pending = s_r.pending;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_reload_take;
		cmd_valid && cmd_op == CMD_RELOAD && s_r.st == ST_IDLE;
	endsequence
	sequence s_status_low;
		!init_status_n && !done;
	endsequence
	sequence s_offline_take;
		cmd_valid && cmd_op == CMD_OFFLINE && cmd_mask == 3'h0 && s_r.st == ST_IDLE;
	endsequence

	a_offline_halt: assert property (busy && !s_r.is_bg |-> user_halt)
		else $error("user logic running during offline programming");
	a_bg_runs: assert property (busy && s_r.is_bg |-> $stable(user_halt) && !sram_wr_valid)
		else $error("background programming disturbed user logic");
	a_sram_only_load: assert property (sram_wr_valid |-> $past(s_r.st) == ST_LOAD && done == 1'b0)
		else $error("sram written outside reload");
	a_offline_all: assert property (s_offline_take |=> s_r.mask == MASK_OFF && busy)
		else $error("offline default sectors wrong");
	a_bg_no_feat: assert property (flash_req && s_r.is_bg && busy |-> flash_sec != SEC_FEAT)
		else $error("background touched feature row");
	a_rpll_erase: assert property (rpll_rst_req |-> s_r.is_bg && flash_op == FOP_ERASE && flash_req)
		else $error("pll reset outside background erase");
	a_flash_hold: assert property (flash_req && !flash_ack |=> flash_req && $stable(flash_addr) && $stable(flash_sec))
		else $error("flash request dropped before ack");
	a_user_spill: assert property (flash_req && flash_op == FOP_READ && s_r.word_idx >= CFG_WORDS |-> flash_sec == SEC_USER)
		else $error("overflow read not from user flash");
	a_reload_low: assert property (s_reload_take |=> s_status_low ##1 (!init_status_n)[*7])
		else $error("reload did not hold init status low");
	a_busy_span: assert property (busy == (s_r.st inside {ST_ERASE, ST_FEAT, ST_IMG}))
		else $error("busy does not match operation");
endmodule
`default_nettype wire

// File: fpmc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_flash_model
	import fpmc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              flash_req,
	input  wire fpmc_fop_t         flash_op,
	input  wire logic [1:0]        flash_sec,
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic [WORD_W-1:0] flash_wdata,
	input  wire logic [2:0]        dly,
	output logic                   flash_ack,
	output logic [WORD_W-1:0]      flash_rdata
);
	// one array per sector, so a stray address never lands in a neighbour
	logic [WORD_W-1:0] mem [3][1024];
	int                er_cnt [3];
	logic [2:0]        wait_r;
	initial begin
		er_cnt = '{0, 0, 0};
	end
	always @(posedge clk) begin
		flash_ack <= 1'b0;
		// released read data keeps changing so a late sample shows up
		flash_rdata <= ~flash_rdata;
		if (srst) begin
			wait_r <= 3'h0;
			flash_rdata <= 32'h5a5a5a5a;
		end else if (flash_req && !flash_ack) begin
			if (wait_r < dly) begin
				wait_r <= wait_r + 3'h1;
			end else begin
				wait_r <= 3'h0;
				flash_ack <= 1'b1;
				case (flash_op)
					FOP_ERASE: begin
						er_cnt[flash_sec] <= er_cnt[flash_sec] + 1;
						for (int i = 0; i < 1024; i++) begin
							mem[flash_sec][i] <= '1;
						end
					end
					FOP_PROG: mem[flash_sec][flash_addr] <= flash_wdata;
					default: flash_rdata <= mem[flash_sec][flash_addr];
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: test_fpmc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_fpmc_top
	import fpmc_pkg::*;
;
	logic              clk = 0, srst = 1, cmd_valid = 0, wr_valid = 0, wr_last = 0;
	fpmc_cmd_t         cmd_op = CMD_NONE;
	logic [2:0]        cmd_mask = 3'h0, dly = 3'h1;
	logic [1:0]        sector_role = ROLE_IMAGE, flash_sec;
	logic [WORD_W-1:0] wr_data = 32'h0, flash_wdata, flash_rdata, sram_wdata;
	logic [ADDR_W-1:0] flash_addr;
	fpmc_fop_t         flash_op;
	logic              wr_ready, flash_req, flash_ack, sram_wr_valid, busy, user_halt;
	logic              init_status_n, done, rpll_rst_req, range_err, image_pending;
	logic              halt_exp = 0, halt_bad = 0, rp_seen = 0;
	int                n_fail = 0, compares = 0, ld_idx = 0;
	fpmc_top u_dut (.clk, .srst, .cmd_valid, .cmd_op, .cmd_mask, .sector_role, .wr_valid, .wr_data,
		.wr_last, .wr_ready, .flash_req, .flash_op, .flash_sec, .flash_addr, .flash_wdata,
		.flash_ack, .flash_rdata, .sram_wr_valid, .sram_wdata, .busy, .user_halt,
		.init_status_n, .done, .rpll_rst_req, .range_err, .image_pending);
	fpmc_flash_model u_flash (.clk, .srst, .flash_req, .flash_op, .flash_sec, .flash_addr,
		.flash_wdata, .dly, .flash_ack, .flash_rdata);
	always #4 clk = ~clk;
	function automatic logic [31:0] val(input int i);
		return 32'hc0de0000 ^ i;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// outputs are registered, so the negedge shows what the next posedge samples
	always @(negedge clk) begin
		if (busy === 1'b1 && user_halt !== halt_exp)
			halt_bad = 1;
		if (rpll_rst_req === 1'b1)
			rp_seen = 1;
		if (sram_wr_valid === 1'b1) begin
			chk("sram_wdata", val(ld_idx), sram_wdata);
			ld_idx++;
		end
	end
	task automatic cmd(input fpmc_cmd_t op, input logic [2:0] m);
		cmd_valid = 1;
		cmd_op = op;
		cmd_mask = m;
		@(posedge clk);
		#1;
		cmd_valid = 0;
		cmd_op = CMD_NONE;
	endtask
	// valid stays high between words; the caller drops it after the burst
	task automatic send(input logic [31:0] d, input logic l);
		wr_valid = 1;
		wr_data = d;
		wr_last = l;
		@(negedge clk);
		while (wr_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		#1;
	endtask
	task automatic prog(input fpmc_cmd_t op, input int n, input logic [1:0] role, input logic err, input logic [2:0] m);
		int   e0 [3];
		logic fr;
		@(posedge clk);
		#1;
		fr = (op == CMD_OFFLINE);
		e0 = u_flash.er_cnt;
		sector_role = role;
		halt_exp = fr;
		halt_bad = 0;
		rp_seen = 0;
		cmd(op, m);
		chk("busy", 1, busy);
		@(posedge clk);
		#1;
		cmd(CMD_RELOAD, 3'h0);
		chk("refused reload", 1, init_status_n);
		for (int k = 0; k < 4 && fr; k++)
			send(32'hfe000000 + k, 1'b0);
		for (int i = 0; i < n; i++)
			send(val(i), i == n - 1);
		wr_valid = 0;
		for (int t = 0; t < 20000 && busy !== 1'b0; t++)
			@(negedge clk);
		chk("busy end", 0, busy);
		chk("halt during", 0, halt_bad);
		chk("rpll", !fr, rp_seen);
		chk("range_err", err, range_err);
		chk("pending", !fr, image_pending);
		for (int s = 0; s < 3; s++)
			chk("erase", s < 2 || fr, u_flash.er_cnt[s] - e0[s]);
	endtask
	task automatic reload(input int n);
		@(posedge clk);
		#1;
		ld_idx = 0;
		cmd(CMD_RELOAD, 3'h0);
		chk("init low", 0, init_status_n);
		chk("done low", 0, done);
		chk("pending clr", 0, image_pending);
		repeat (INIT_CYC) @(negedge clk);
		chk("init held", 0, init_status_n);
		@(negedge clk);
		chk("init high", 1, init_status_n);
		for (int t = 0; t < 20000 && done !== 1'b1; t++)
			@(negedge clk);
		chk("done", 1, done);
		chk("loaded", n, ld_idx);
		chk("halt off", 0, user_halt);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1;
		srst = 0;
		chk("halt rst", 1, user_halt);
		chk("done rst", 0, done);
		chk("init rst", 1, init_status_n);
		dly = 3'h3;
		prog(CMD_OFFLINE, 3, ROLE_IMAGE, 1'b0, 3'h0);
		for (int k = 0; k < 4; k++)
			chk("feature", 32'hfe000000 + k, u_flash.mem[SEC_FEAT][k]);
		reload(3);
		dly = 3'h0;
		ld_idx = 0;
		prog(CMD_BACKGROUND, 1026, ROLE_IMAGE, 1'b0, 3'h7);
		chk("sram quiet", 0, ld_idx);
		chk("done kept", 1, done);
		chk("spill", val(1025), u_flash.mem[SEC_USER][1]);
		reload(1026);
		dly = 3'h2;
		prog(CMD_OFFLINE, 1025, ROLE_BRAM, 1'b1, 3'h0);
		chk("cfg end", val(1023), u_flash.mem[SEC_CFG][1023]);
		chk("no spill", 32'hffffffff, u_flash.mem[SEC_USER][0]);
		tally_and_finish;
	end
	initial begin
		#400000;
		n_fail++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
